// *** rtl/acsc_params.svh ***
// Register offsets, field positions and reset values of the converter sequencer
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACSC_OFS_RESULT_LO 8'hD1
`define ACSC_OFS_RESULT_HI 8'hD2
`define ACSC_OFS_CFG 8'hD5
`define ACSC_OFS_SEQ 8'hD6
`define ACSC_OFS_TIMING 8'hD7
`define ACSC_OFS_MODE 8'hDD

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACSC_SEQ_START 7
`define ACSC_SEQ_ACC_HI 6
`define ACSC_SEQ_ACC_LO 4
`define ACSC_SEQ_AVE_DIS 3
`define ACSC_SEQ_TRIG_SEL 2
`define ACSC_SEQ_AS_CONV 1
`define ACSC_SEQ_OVF 0
`define ACSC_TIM_LOW_SPEED 7
`define ACSC_TIM_SES_HI 6
`define ACSC_TIM_SES_LO 4
`define ACSC_TIM_IDLE_RUN 3
`define ACSC_TIM_WAIT_RD 2
`define ACSC_TIM_STA_HI 1
`define ACSC_TIM_STA_LO 0
`define ACSC_CFG_ENABLE 6
`define ACSC_CFG_WAIT_RD_EN 4
`define ACSC_CFG_DIV_HI 3
`define ACSC_CFG_DIV_LO 1
`define ACSC_MODE_INJECT 7
`define ACSC_MODE_PUMP 6
`define ACSC_MODE_CCM 3

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define ACSC_RST_BYTE 8'h00
`define ACSC_RST_SUM 16'h0000
`define ACSC_RST_CNT 12'h000
`define ACSC_ONE_CNT 12'h001
`define ACSC_RST_DIV 7'h00

`endif

// *** rtl/acsc_pkg.sv ***
// Types shared by the converter sequencer
package acsc_pkg;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ACSC_IDLE = 3'b000,
		ACSC_START_GAP = 3'b001,
		ACSC_CONVERT = 3'b010,
		ACSC_WAIT_READ = 3'b011,
		ACSC_SES_GAP = 3'b100
	} acsc_state_t;

endpackage : acsc_pkg

// *** rtl/acsc_prescaler.sv ***
// Power-of-two prescaler giving one converter clock tick per period
`timescale 1ns/100ps
`include "acsc_params.svh"

module acsc_prescaler (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_run,
	input wire logic [2:0] i_div_sel,
	output logic o_tick
);

	logic [6:0] cnt_q;
	logic [6:0] mask;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// Low bits all ones marks the end of one divided period
	assign mask = 7'((8'h01 << i_div_sel) - 8'h01);
	assign o_tick = i_run && ((cnt_q & mask) == mask);

	// Free counter, held at zero so each run starts with a full period
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || !i_run) begin
			cnt_q <= `ACSC_RST_DIV;
		end else begin
			cnt_q <= cnt_q + 7'd1;
		end
	end

endmodule : acsc_prescaler

// *** rtl/acsc_top.sv ***
// Converter sequence control: registers, start and session timing, accumulation
`timescale 1ns/100ps
`include "acsc_params.svh"

// Functional notes
// - Start bit launches an operation and self-clears when it ends.
// - Accumulation code 0..3,7 sums 1,2,4,8,128 conversions.
// - Sum overflow sets the sticky accumulation overflow flag.
// - Average-disable bit set bypasses averaging; clear applies it.
// - Trigger-select picks event source: data valid or threshold crossing.
// - Low-speed bit puts converter into low-power low-speed mode.
// - Session gap of 0..2048 slow ticks between accumulation sessions.
// - Idle-run flag holds unfinished idle work; hardware or CPU clears.
// - Wait-for-read flag set while stalled; CPU writes zero after reading.
// - Start gap of 2,4,8,16 converter clocks between start triggers.
// - Inject waits for current conversion, then converts channel 15 until software clears the bit.
// - Hardware never changes the inject bit; only software does.
// - Pump-enable bit is forwarded to the converter.
// - Continuous-conversion bit enables continuous conversion mode.
// - Wait-for-read enable holds next conversion until software clears the wait-for-read flag.
// - Converter clock is system clock divided by 1 to 128.
// - Conversions run only while the converter enable bit is set.
module acsc_top
	import acsc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_slow_tick_clock,
	input wire logic i_go_idle,
	input wire logic i_conv_done,
	input wire logic [10:0] i_conv_data,
	input wire logic i_thresh_cross,
	output logic o_conv_enable,
	output logic o_conv_start,
	output logic o_adc_clk_tick,
	output logic o_inject_ch15,
	output logic o_low_speed,
	output logic o_pump_en,
	output logic o_irq_event,
	output logic [15:0] o_result
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Number of conversions per session, doubling per code
	function automatic logic [11:0] acc_count(input logic [2:0] code);
		acc_count = 12'(`ACSC_ONE_CNT << code);
	endfunction : acc_count

	// Slow ticks between sessions
	function automatic logic [11:0] ses_ticks(input logic [2:0] code);
		case (code)
			3'h0: ses_ticks = 12'h000;
			3'h1: ses_ticks = 12'h008;
			3'h2: ses_ticks = 12'h020;
			3'h3: ses_ticks = 12'h080;
			3'h4: ses_ticks = 12'h100;
			3'h5: ses_ticks = 12'h200;
			3'h6: ses_ticks = 12'h400;
			default: ses_ticks = 12'h800;
		endcase
	endfunction : ses_ticks

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	acsc_state_t state_q, state_d;
	logic [7:0] cfg_q, seq_q, tim_q, mode_q;
	logic [15:0] sum_q, result_q;
	logic [11:0] done_q, gap_q;
	logic [7:0] rdata_q;
	logic inject_q;
	logic [2:0] slow_sync_q;
	logic slow_edge, adc_tick, slow_lvl_q;
	logic wr_cfg, wr_seq, wr_tim, wr_mode, rd_hi;
	logic enable, op_end, sess_end, conv_accept, finish;
	logic [16:0] sum_next;
	logic [15:0] avg;
	logic [11:0] target;
	logic sta_gap_done, ses_gap_done, ses_gap_zero;
	logic data_valid;
	logic [7:0] rd_mux;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	assign wr_cfg = i_wr && (i_addr == `ACSC_OFS_CFG);
	assign wr_seq = i_wr && (i_addr == `ACSC_OFS_SEQ);
	assign wr_tim = i_wr && (i_addr == `ACSC_OFS_TIMING);
	assign wr_mode = i_wr && (i_addr == `ACSC_OFS_MODE);
	assign rd_hi = i_rd && (i_addr == `ACSC_OFS_RESULT_HI);
	assign enable = cfg_q[`ACSC_CFG_ENABLE];
	assign target = acc_count(seq_q[`ACSC_SEQ_ACC_HI:`ACSC_SEQ_ACC_LO]);

	// Accumulation, one spare bit catches the carry
	assign conv_accept = (state_q == ACSC_CONVERT) && i_conv_done;
	assign sum_next = {1'b0, sum_q} + {6'h00, i_conv_data};
	assign finish = conv_accept && ((done_q + 12'h001) == target);
	assign avg = sum_next[15:0] >> seq_q[`ACSC_SEQ_ACC_HI:`ACSC_SEQ_ACC_LO];

	// Start gap counts 2 << code converter clocks
	assign sta_gap_done = adc_tick &&
		((gap_q + 12'h001) >= 12'(12'h002 << tim_q[`ACSC_TIM_STA_HI:`ACSC_TIM_STA_LO]));
	assign ses_gap_zero = (ses_ticks(tim_q[`ACSC_TIM_SES_HI:`ACSC_TIM_SES_LO]) == 12'h000);
	assign ses_gap_done = ses_gap_zero || (slow_edge &&
		((gap_q + 12'h001) >= ses_ticks(tim_q[`ACSC_TIM_SES_HI:`ACSC_TIM_SES_LO])));

	// Session ends on last conversion; operation ends unless continuous or wait-for-read is enabled
	assign sess_end = finish;
	assign op_end = finish && !mode_q[`ACSC_MODE_CCM] && !cfg_q[`ACSC_CFG_WAIT_RD_EN];
	assign data_valid = finish;

	// ----------------------------------------
	// Slow tick synchroniser
	// ----------------------------------------
	// Edge counts only once stages two and three agree on the new level
	assign slow_edge = slow_sync_q[1] && slow_sync_q[2] && !slow_lvl_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			slow_sync_q <= 3'h0;
			slow_lvl_q <= 1'b0;
		end else begin
			slow_sync_q <= {slow_sync_q[1:0], i_slow_tick_clock};
			if (slow_sync_q[1] == slow_sync_q[2]) begin
				slow_lvl_q <= slow_sync_q[2];
			end
		end
	end

	// ----------------------------------------
	// Converter clock
	// ----------------------------------------
	acsc_prescaler u_prescaler (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_run(enable),
		.i_div_sel(cfg_q[`ACSC_CFG_DIV_HI:`ACSC_CFG_DIV_LO]),
		.o_tick(adc_tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Next state; clearing the enable drops any operation at once
	always_comb begin
		state_d = state_q;
		case (state_q)
			ACSC_IDLE: begin
				if (enable && seq_q[`ACSC_SEQ_START]) begin
					state_d = ACSC_START_GAP;
				end
			end
			ACSC_START_GAP: begin
				if (sta_gap_done) begin
					state_d = ACSC_CONVERT;
				end
			end
			ACSC_CONVERT: begin
				if (finish && cfg_q[`ACSC_CFG_WAIT_RD_EN]) begin
					state_d = ACSC_WAIT_READ;
				end else if (finish && mode_q[`ACSC_MODE_CCM]) begin
					state_d = ACSC_SES_GAP;
				end else if (finish) begin
					state_d = ACSC_IDLE;
				end else if (conv_accept) begin
					state_d = ACSC_START_GAP;
				end
			end
			ACSC_WAIT_READ: begin
				// Held until software clears the wait flag after the read
				if (!tim_q[`ACSC_TIM_WAIT_RD]) begin
					state_d = mode_q[`ACSC_MODE_CCM] ? ACSC_SES_GAP : ACSC_IDLE;
				end
			end
			ACSC_SES_GAP: begin
				if (ses_gap_done) begin
					state_d = mode_q[`ACSC_MODE_CCM] ? ACSC_START_GAP : ACSC_IDLE;
				end
			end
			default: state_d = ACSC_IDLE;
		endcase
		if (!enable) begin
			state_d = ACSC_IDLE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_q <= ACSC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Gap counter is shared by both gap states and restarts on entry
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || (state_d != state_q)) begin
			gap_q <= `ACSC_RST_CNT;
		end else if ((state_q == ACSC_START_GAP && adc_tick) ||
			(state_q == ACSC_SES_GAP && slow_edge)) begin
			gap_q <= gap_q + 12'h001;
		end
	end

	// Running sum and conversion count, cleared at each session end
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || state_q == ACSC_IDLE || sess_end) begin
			sum_q <= `ACSC_RST_SUM;
			done_q <= `ACSC_RST_CNT;
		end else if (conv_accept) begin
			sum_q <= sum_next[15:0];
			done_q <= done_q + 12'h001;
		end
	end

	// Result register
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			result_q <= `ACSC_RST_SUM;
		end else if (finish) begin
			result_q <= seq_q[`ACSC_SEQ_AVE_DIS] ? sum_next[15:0] : avg;
		end
	end

	// Channel 15 swaps in only between conversions, never mid-sample
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			inject_q <= 1'b0;
		end else if (state_q != ACSC_CONVERT) begin
			inject_q <= mode_q[`ACSC_MODE_INJECT];
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Plain configuration and mode bytes; inject changes by writes only
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			cfg_q <= `ACSC_RST_BYTE;
			mode_q <= `ACSC_RST_BYTE;
		end else begin
			if (wr_cfg) begin
				cfg_q <= i_wdata;
			end
			if (wr_mode) begin
				mode_q <= i_wdata;
			end
		end
	end

	// Sequence byte: start self-clears, overflow is sticky and set wins
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			seq_q <= `ACSC_RST_BYTE;
		end else begin
			if (wr_seq) begin
				seq_q <= i_wdata;
			end
			if ((op_end || (state_q == ACSC_WAIT_READ && state_d == ACSC_IDLE)) && !wr_seq) begin
				seq_q[`ACSC_SEQ_START] <= 1'b0;
			end
			if (conv_accept && sum_next[16]) begin
				seq_q[`ACSC_SEQ_OVF] <= 1'b1;
			end
		end
	end

	// Timing byte: wait and idle-run flags set by hardware win over writes
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			tim_q <= `ACSC_RST_BYTE;
		end else begin
			if (wr_tim) begin
				tim_q <= i_wdata;
			end
			if (state_q == ACSC_IDLE && state_d == ACSC_IDLE && !wr_tim) begin
				tim_q[`ACSC_TIM_IDLE_RUN] <= 1'b0;
			end
			if (i_go_idle && state_q != ACSC_IDLE) begin
				tim_q[`ACSC_TIM_IDLE_RUN] <= 1'b1;
			end
			if (finish && cfg_q[`ACSC_CFG_WAIT_RD_EN]) begin
				tim_q[`ACSC_TIM_WAIT_RD] <= 1'b1;
			end
		end
	end

	// Read data stand the cycle after the strobe; unmapped reads give zero
	assign rd_mux = (i_addr == `ACSC_OFS_RESULT_LO) ? result_q[7:0] :
		rd_hi ? result_q[15:8] :
		(i_addr == `ACSC_OFS_CFG) ? cfg_q :
		(i_addr == `ACSC_OFS_SEQ) ? seq_q :
		(i_addr == `ACSC_OFS_TIMING) ? tim_q :
		(i_addr == `ACSC_OFS_MODE) ? mode_q : `ACSC_RST_BYTE;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			rdata_q <= `ACSC_RST_BYTE;
		end else begin
			rdata_q <= i_rd ? rd_mux : `ACSC_RST_BYTE;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rdata = rdata_q;
	assign o_result = result_q;
	assign o_conv_enable = enable;
	assign o_adc_clk_tick = adc_tick;
	assign o_conv_start = (state_q == ACSC_START_GAP) && sta_gap_done;
	assign o_inject_ch15 = inject_q;
	assign o_low_speed = tim_q[`ACSC_TIM_LOW_SPEED];
	assign o_pump_en = mode_q[`ACSC_MODE_PUMP];
	// Event source chosen only while the converter function is selected
	assign o_irq_event = enable && seq_q[`ACSC_SEQ_AS_CONV] &&
		(seq_q[`ACSC_SEQ_TRIG_SEL] ? i_thresh_cross : data_valid);

endmodule : acsc_top

// *** sim/acsc_properties.sv ***
// Port-level assertions for the converter sequencer
`timescale 1ns/100ps
`include "acsc_params.svh"
module acsc_checker (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_conv_done,
	input wire logic i_thresh_cross,
	input wire logic o_conv_enable,
	input wire logic o_conv_start,
	input wire logic o_adc_clk_tick,
	input wire logic o_low_speed,
	input wire logic o_pump_en,
	input wire logic o_irq_event,
	input wire logic [15:0] o_result
);
	// One clock domain, so clocking and reset are stated once
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	// Converter ticks since the last conversion-done pulse, saturating at three
	logic [1:0] ticks_q;
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ticks_q <= 2'd3;
		end else if (i_conv_done) begin
			ticks_q <= 2'd0;
		end else if (o_adc_clk_tick && ticks_q != 2'd3) begin
			ticks_q <= ticks_q + 2'd1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_START_NEEDS_EN: assert property (o_conv_start |-> o_conv_enable)
		else $error("start while disabled");
	AST_START_ON_TICK: assert property (o_conv_start |-> o_adc_clk_tick)
		else $error("start off the converter tick");
	AST_START_SPACED: assert property (o_conv_start |-> ticks_q != 2'd0)
		else $error("starts closer than the gap");
	AST_IRQ_CAUSE: assert property (o_irq_event |-> i_conv_done || i_thresh_cross)
		else $error("event without a source");
	// Result may move only after a conversion lands or a bus write
	AST_RESULT_CAUSE: assert property ($changed(o_result) |->
		$past(i_conv_done) || $past(i_conv_done, 2) || $past(i_wr))
		else $error("result changed without cause");
	AST_PUMP_WRITE: assert property ($changed(o_pump_en) |->
		$past(i_wr) && $past(i_addr) == `ACSC_OFS_MODE)
		else $error("pump level moved without write");
	AST_LOW_SPEED_WRITE: assert property ($changed(o_low_speed) |->
		$past(i_wr) && $past(i_addr) == `ACSC_OFS_TIMING)
		else $error("low speed moved without write");
	AST_ENABLE_WRITE: assert property ($changed(o_conv_enable) |->
		$past(i_wr) && $past(i_addr) == `ACSC_OFS_CFG)
		else $error("enable moved without write");

	// Main scenarios reached
	COV_IRQ: cover property (o_irq_event);
	COV_START_DONE: cover property (o_conv_start ##[1:12] i_conv_done);
	COV_RESULT: cover property ($changed(o_result));
endmodule : acsc_checker

bind acsc_top acsc_checker u_chk (
	.i_sys_clk(i_sys_clk),
	.i_srst(i_srst),
	.i_addr(i_addr),
	.i_wr(i_wr),
	.i_conv_done(i_conv_done),
	.i_thresh_cross(i_thresh_cross),
	.o_conv_enable(o_conv_enable),
	.o_conv_start(o_conv_start),
	.o_adc_clk_tick(o_adc_clk_tick),
	.o_low_speed(o_low_speed),
	.o_pump_en(o_pump_en),
	.o_irq_event(o_irq_event),
	.o_result(o_result)
);

// *** sim/acsc_conv_model.sv ***
// Behavioural converter core answering start pulses
`timescale 1ns/100ps
module acsc_conv_model (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_start,
	input wire logic i_enable,
	input wire logic i_slow,
	input wire logic [10:0] i_value,
	output logic o_done,
	output logic [10:0] o_data
);
	logic [3:0] cnt_q = 4'h0;
	logic [10:0] junk_q = 11'h000;
	// Countdown from start to done; slow mode stretches the conversion
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || !i_enable) begin
			cnt_q <= 4'h0;
		end else if (i_start) begin
			cnt_q <= i_slow ? 4'h9 : 4'h2;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// Data toggles outside done so a stale sample is never trusted
	always_ff @(posedge i_sys_clk) begin
		junk_q <= ~junk_q;
	end
	assign o_done = (cnt_q == 4'h1);
	assign o_data = o_done ? i_value : junk_q;
endmodule : acsc_conv_model

// *** sim/testbench.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "acsc_params.svh"
module testbench;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_slow_tick_clock = 1'b0;
	logic i_thresh_cross = 1'b0;
	logic i_go_idle = 1'b0;
	// Slow tick period in system clocks (200 ns over 5 ns), threshold pulse spacing
	localparam int SLOW_CYC = 40;
	localparam int THR_CYC = 37;
	int irq_at = 0;
	int irq_gap = 0;
	int tick_cnt = 0;
	int n0 = 0;
	logic slow_q = 1'b0;
	logic [10:0] value_q = 11'h000;
	logic i_conv_done;
	logic [10:0] i_conv_data;
	logic [7:0] o_rdata;
	logic [7:0] b;
	logic o_conv_enable, o_conv_start, o_adc_clk_tick, o_inject_ch15;
	logic o_low_speed, o_pump_en, o_irq_event;
	logic [15:0] o_result;
	logic [31:0] lfsr_q = 32'h0000_f8d3;
	logic [7:0] regs [5] = '{`ACSC_OFS_CFG, `ACSC_OFS_SEQ, `ACSC_OFS_TIMING, `ACSC_OFS_MODE, 8'h10};
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int irq_cnt = 0;

	acsc_top DUT (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_slow_tick_clock(i_slow_tick_clock),
		.i_go_idle(i_go_idle),
		.i_conv_done(i_conv_done),
		.i_conv_data(i_conv_data),
		.i_thresh_cross(i_thresh_cross),
		.o_conv_enable(o_conv_enable),
		.o_conv_start(o_conv_start),
		.o_adc_clk_tick(o_adc_clk_tick),
		.o_inject_ch15(o_inject_ch15),
		.o_low_speed(o_low_speed),
		.o_pump_en(o_pump_en),
		.o_irq_event(o_irq_event),
		.o_result(o_result)
	);
	acsc_conv_model u_conv (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_start(o_conv_start),
		.i_enable(o_conv_enable),
		.i_slow(slow_q),
		.i_value(value_q),
		.o_done(i_conv_done),
		.o_data(i_conv_data)
	);

	// ----------------------------------------
	// Clocks, timeout, event counting
	// ----------------------------------------
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	always #100 i_slow_tick_clock = ~i_slow_tick_clock;
	// Threshold pulses must not add events while data-valid is selected
	always @(posedge i_sys_clk) begin
		cyc++;
		i_thresh_cross <= (cyc % THR_CYC == 0);
		if (o_irq_event === 1'b1) begin
			irq_cnt++;
			irq_gap = cyc - irq_at;
			irq_at = cyc;
		end
		if (o_adc_clk_tick === 1'b1)
			tick_cnt++;
		if (cyc == 40000) begin
			errors++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Overflow flag above the expected 16-bit result
	function automatic logic [16:0] expect_of(input logic [2:0] a, input logic ad,
		input logic [10:0] v);
		logic [17:0] s;
		s = 18'(v) << a;
		return {s[17:16] != 2'b00, ad ? s[15:0] : 16'(s >> a)};
	endfunction : expect_of
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	// One operation: start, poll for self-clear, then check result and flags
	task automatic session(input logic [2:0] a, input logic ad, input logic [10:0] v);
		logic [7:0] s;
		logic [7:0] lo;
		logic [16:0] ex;
		ex = expect_of(a, ad, v);
		value_q <= v;
		irq_cnt = 0;
		wr(`ACSC_OFS_CFG, 8'h40);
		wr(`ACSC_OFS_SEQ, {1'b1, a, ad, 3'b010});
		s = 8'h80;
		for (int k = 0; k < 3000 && s[7]; k++)
			rd(`ACSC_OFS_SEQ, s);
		chk(16'(s[7]), 16'h0000);
		chk(16'(s[0]), 16'(ex[16]));
		rd(`ACSC_OFS_RESULT_LO, lo);
		rd(`ACSC_OFS_RESULT_HI, s);
		if (!ex[16])
			chk({s, lo}, ex[15:0]);
		chk(16'(irq_cnt), 16'h0001);
		wr(`ACSC_OFS_SEQ, 8'h02);
	endtask : session
	task automatic print_verdict();
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i], b);
			chk(16'(b), 16'h0000);
		end
		wr(`ACSC_OFS_MODE, 8'hc0);
		wr(`ACSC_OFS_TIMING, 8'h80);
		rd(`ACSC_OFS_MODE, b);
		chk({o_inject_ch15, o_pump_en, o_low_speed, 5'h00, b}, 16'he0c0);
		wr(`ACSC_OFS_MODE, 8'h00);
		wr(`ACSC_OFS_TIMING, 8'h00);
		for (int a = 0; a < 8; a++) begin
			lfsr_q = lfsr(lfsr_q);
			slow_q <= lfsr_q[12];
			session(3'(a), lfsr_q[3], lfsr_q[10:0]);
		end
		session(3'h7, 1'b1, 11'h7ff);
		session(3'h7, 1'b0, 11'h1ff);
		// Wait-for-read: process stalls until the flag is written to zero
		wr(`ACSC_OFS_CFG, 8'h50);
		wr(`ACSC_OFS_SEQ, 8'h82);
		b = 8'h00;
		for (int k = 0; k < 200 && !b[2]; k++)
			rd(`ACSC_OFS_TIMING, b);
		chk(16'(b[2]), 16'h0001);
		rd(`ACSC_OFS_SEQ, b);
		chk(16'(b[7]), 16'h0001);
		wr(`ACSC_OFS_TIMING, 8'h00);
		rd(`ACSC_OFS_SEQ, b);
		chk(16'(b[7]), 16'h0000);
		// Continuous mode: mode bit before start, sessions spaced by eight slow ticks
		wr(`ACSC_OFS_CFG, 8'h40);
		wr(`ACSC_OFS_TIMING, 8'h10);
		wr(`ACSC_OFS_MODE, 8'h08);
		wr(`ACSC_OFS_SEQ, 8'h82);
		#1 irq_cnt = 0;
		for (int k = 0; k < 3000 && irq_cnt < 3; k++)
			@(posedge i_sys_clk);
		chk(16'(irq_gap >= 7 * SLOW_CYC && irq_gap <= 8 * SLOW_CYC + 20), 16'h0001);
		rd(`ACSC_OFS_SEQ, b);
		chk(16'(b[7]), 16'h0001);
		// Go-idle while busy marks unfinished work; cleared once the run ends
		@(posedge i_sys_clk);
		i_go_idle <= 1'b1;
		@(posedge i_sys_clk);
		i_go_idle <= 1'b0;
		rd(`ACSC_OFS_TIMING, b);
		chk(16'(b[3]), 16'h0001);
		wr(`ACSC_OFS_MODE, 8'h00);
		b = 8'h80;
		for (int k = 0; k < 300 && b[7]; k++)
			rd(`ACSC_OFS_SEQ, b);
		chk(16'(b[7]), 16'h0000);
		rd(`ACSC_OFS_TIMING, b);
		chk(16'(b[3]), 16'h0000);
		// Threshold source: one event per threshold pulse
		wr(`ACSC_OFS_SEQ, 8'h06);
		#1 n0 = irq_cnt;
		repeat (10 * THR_CYC) @(posedge i_sys_clk);
		#1;
		chk(16'(irq_cnt - n0), 16'h000a);
		// Divide by eight: 80 cycles hold ten converter ticks
		wr(`ACSC_OFS_CFG, 8'h46);
		#1 n0 = tick_cnt;
		repeat (80) @(posedge i_sys_clk);
		#1;
		chk(16'(tick_cnt - n0), 16'h000a);
		print_verdict();
	end
endmodule : testbench
